/* rtl/access_fault_check.sv */
// answers a unit access with fault or normal completion
// assumes the request is a one-cycle pulse from the top module
module access_fault_check
  import clock_gating_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     sys_rst,
  gated_access_if.chk   acc
);

  typedef struct packed {
    logic fault;
    logic ok;
  } chk_state_t;

  chk_state_t s_q;
  chk_state_t s_d;

  // ----------------------------------------------------------------
  // decide answer one cycle after the request
  // ----------------------------------------------------------------
  always_comb begin
    s_d = '{fault: 1'b0, ok: 1'b0};
    if (acc.req && acc.unit < 3'(unit_count)) begin
      s_d.fault = !acc.enables[acc.unit];
      s_d.ok    = acc.enables[acc.unit];
    end else if (acc.req) begin
      s_d.fault = 1'b1; // no such unit: never clocked
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{fault: 1'b0, ok: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign acc.fault = s_q.fault;
  assign acc.ok    = s_q.ok;

endmodule

/* rtl/clock_gating_pkg.sv */
// constants shared by the clock gating block and its access checker
// assumes a 32-bit apb register bus and a single system clock
package clock_gating_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] run_gating_set0_off        = 12'h100;
  localparam logic [11:0] run_gating_set1_off        = 12'h104;
  localparam logic [11:0] sleep_gating_set0_off      = 12'h110;
  localparam logic [11:0] sleep_gating_set1_off      = 12'h114;
  localparam logic [11:0] deep_sleep_gating_set0_off = 12'h120;
  localparam logic [11:0] deep_sleep_gating_set1_off = 12'h124;
  localparam logic [11:0] run_clock_config_off       = 12'h060;
  localparam logic [11:0] int_status_off             = 12'h050;
  localparam logic [11:0] int_mask_off               = 12'h054;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int watchdog_bit       = 3;
  localparam int adc_rate_lsb       = 8;
  localparam int adc_rate_msb       = 11;
  localparam int adc_zero_bit       = 16;
  localparam int pwm_bit            = 20;
  localparam int async_serial_bit   = 0;
  localparam int sync_serial_bit    = 4;
  localparam int gp_timer_zero_bit  = 16;
  localparam int auto_gating_bit    = 27;

  // writable bits of each register; all others read zero
  localparam logic [31:0] set0_mask   = 32'h0011_0f08;
  localparam logic [31:0] set1_mask   = 32'h0001_0011;
  localparam logic [31:0] config_mask = 32'h0800_0000;
  localparam logic [31:0] irq_mask    = 32'h0000_0003;
  localparam logic [31:0] reset_value = 32'h0000_0000;

  // adc sample rate codes
  localparam logic [3:0] adc_rate_125k = 4'h0;
  localparam logic [3:0] adc_rate_250k = 4'h1;

  // unit indices of the gated clock vector
  localparam int unit_count        = 6;
  localparam int unit_watchdog     = 0;
  localparam int unit_adc          = 1;
  localparam int unit_pwm          = 2;
  localparam int unit_timer        = 3;
  localparam int unit_sync_serial  = 4;
  localparam int unit_async_serial = 5;

  // interrupt status bits
  localparam int irq_fault_bit = 0;
  localparam int irq_mode_bit  = 1;

  // processor power state
  typedef enum logic [1:0] {
    pwr_run,
    pwr_sleep,
    pwr_deep_sleep
  } power_state_t;

endpackage

/* rtl/gated_access_if.sv */
// carries a unit-access request and the gated enables to the checker
// assumes the checker sits on the same clock as the top module
interface gated_access_if;
  import clock_gating_pkg::*;
  logic                  req;
  logic [2:0]            unit;
  logic [unit_count-1:0] enables;
  logic                  fault;
  logic                  ok;
  modport top (output req, output unit, output enables, input fault, input ok);
  modport chk (input req, input unit, input enables, output fault, output ok);
endinterface

/* rtl/peripheral_clock_gating.sv */
// peripheral clock gating: run, sleep and deep-sleep enable sets
// assumes apb master on clk, power state from the processor on clk
//
// What this block does
// - set bit clocks unit, clear bit stops it
// - access to unclocked unit answers bus fault
// - all gating bits reset to zero
// - separate run, sleep and deep-sleep sets
// - sleep sets used only with auto gating
// - set0 bit 3 enables watchdog clock
// - set0 bits 11:8 select adc rate
// - run set1 bit 16 enables timer zero
// - reserved bits read zero, ignore writes
// - unimplemented unit bits behave as reserved
// - set1 bit 4 enables sync serial
// - set1 bit 0 enables async serial
//
// Our own choice: the APB register port.
module peripheral_clock_gating
  import clock_gating_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // processor power state, same clock domain
  input  wire logic                  sleeping,
  input  wire logic                  deep_sleep,
  // peripheral access port, one-cycle request
  input  wire logic                  unit_req,
  input  wire logic [2:0]            unit_sel,
  output logic                       unit_fault,
  output logic                       unit_ok,
  // gated outputs
  output logic                       watchdog_unit_clk,
  output logic                       adc_zero_clk,
  output logic                       pwm_unit_clk,
  output logic                       gp_timer_zero_clk,
  output logic                       sync_serial_zero_clk,
  output logic                       async_serial_zero_clk,
  output logic [3:0]                 adc_sample_rate_sel,
  output logic                       irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0]           run0;
    logic [31:0]           run1;
    logic [31:0]           sleep0;
    logic [31:0]           sleep1;
    logic [31:0]           deep0;
    logic [31:0]           deep1;
    logic [31:0]           cfg;
    logic [31:0]           status;
    logic [31:0]           mask;
    logic [31:0]           rdata;
    logic [unit_count-1:0] en;
    logic [3:0]            rate;
    power_state_t          pwr;
  } gate_state_t;

  gate_state_t s_q;
  gate_state_t s_d;

  gated_access_if acc ();

  logic wr_stb;
  logic rd_stb;
  logic hit;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // masked write keeps reserved positions at zero
  function automatic logic [31:0] wr_mask(input logic [31:0] d, input logic [31:0] m);
    return d & m;
  endfunction

  // unit enable vector from one set0 and one set1 register
  function automatic logic [unit_count-1:0] unit_enables(input logic [31:0] r0, input logic [31:0] r1);
    logic [unit_count-1:0] e;
    e = '0;
    e[unit_watchdog]     = r0[watchdog_bit];
    e[unit_adc]          = r0[adc_zero_bit];
    e[unit_pwm]          = r0[pwm_bit];
    e[unit_timer]        = r1[gp_timer_zero_bit];
    e[unit_sync_serial]  = r1[sync_serial_bit];
    e[unit_async_serial] = r1[async_serial_bit];
    return e;
  endfunction

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  // zero-wait slave: write and read both complete in the access cycle
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && !penable && !pwrite;

  always_comb begin
    unique case (paddr)
      run_gating_set0_off, run_gating_set1_off, sleep_gating_set0_off,
      sleep_gating_set1_off, deep_sleep_gating_set0_off,
      deep_sleep_gating_set1_off, run_clock_config_off,
      int_status_off, int_mask_off: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata  = s_q.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [unit_count-1:0] sel_en;
    logic [3:0]            sel_rate;
    logic [31:0]           clr;
    logic [31:0]           ev;
    sel_en   = '0;
    sel_rate = '0;
    clr      = '0;
    ev       = '0;
    s_d      = s_q;

    // register writes
    if (wr_stb) begin
      unique case (paddr)
        run_gating_set0_off:        s_d.run0   = wr_mask(pwdata, set0_mask);
        run_gating_set1_off:        s_d.run1   = wr_mask(pwdata, set1_mask);
        sleep_gating_set0_off:      s_d.sleep0 = wr_mask(pwdata, set0_mask);
        sleep_gating_set1_off:      s_d.sleep1 = wr_mask(pwdata, set1_mask);
        deep_sleep_gating_set0_off: s_d.deep0  = wr_mask(pwdata, set0_mask);
        deep_sleep_gating_set1_off: s_d.deep1  = wr_mask(pwdata, set1_mask);
        run_clock_config_off:       s_d.cfg    = wr_mask(pwdata, config_mask);
        int_status_off:             clr        = wr_mask(pwdata, irq_mask);
        int_mask_off:               s_d.mask   = wr_mask(pwdata, irq_mask);
        default: ;
      endcase
    end

    // read data latched in the setup cycle
    if (rd_stb) begin
      unique case (paddr)
        run_gating_set0_off:        s_d.rdata = s_q.run0;
        run_gating_set1_off:        s_d.rdata = s_q.run1;
        sleep_gating_set0_off:      s_d.rdata = s_q.sleep0;
        sleep_gating_set1_off:      s_d.rdata = s_q.sleep1;
        deep_sleep_gating_set0_off: s_d.rdata = s_q.deep0;
        deep_sleep_gating_set1_off: s_d.rdata = s_q.deep1;
        run_clock_config_off:       s_d.rdata = s_q.cfg;
        int_status_off:             s_d.rdata = s_q.status;
        int_mask_off:               s_d.rdata = s_q.mask;
        default:                    s_d.rdata = '0;
      endcase
    end

    // power state: deep sleep wins when both inputs are high
    if (deep_sleep) begin
      s_d.pwr = pwr_deep_sleep;
    end else if (sleeping) begin
      s_d.pwr = pwr_sleep;
    end else begin
      s_d.pwr = pwr_run;
    end

    // choose the set in force; sleep sets only with auto gating
    unique case (s_q.pwr)
      pwr_run: begin
        sel_en   = unit_enables(s_q.run0, s_q.run1);
        sel_rate = s_q.run0[adc_rate_msb:adc_rate_lsb];
      end
      pwr_sleep: begin
        if (s_q.cfg[auto_gating_bit]) begin
          sel_en   = unit_enables(s_q.sleep0, s_q.sleep1);
          sel_rate = s_q.sleep0[adc_rate_msb:adc_rate_lsb];
        end else begin
          sel_en   = unit_enables(s_q.run0, s_q.run1);
          sel_rate = s_q.run0[adc_rate_msb:adc_rate_lsb];
        end
      end
      pwr_deep_sleep: begin
        if (s_q.cfg[auto_gating_bit]) begin
          sel_en   = unit_enables(s_q.deep0, s_q.deep1);
          sel_rate = s_q.deep0[adc_rate_msb:adc_rate_lsb];
        end else begin
          sel_en   = unit_enables(s_q.run0, s_q.run1);
          sel_rate = s_q.run0[adc_rate_msb:adc_rate_lsb];
        end
      end
      default: ;
    endcase
    s_d.en   = sel_en;
    s_d.rate = sel_rate;

    // events: access fault and a change of the power state
    ev[irq_fault_bit] = acc.fault;
    ev[irq_mode_bit]  = (s_d.pwr != s_q.pwr);
    // set wins over a clear in the same cycle
    s_d.status = (s_q.status & ~clr) | ev;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_q <= '{run0: reset_value, run1: reset_value, sleep0: reset_value,
               sleep1: reset_value, deep0: reset_value, deep1: reset_value,
               cfg: reset_value, status: reset_value, mask: reset_value,
               rdata: reset_value, en: '0, rate: adc_rate_125k,
               pwr: pwr_run};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // access checker
  // ----------------------------------------------------------------
  assign acc.req     = unit_req;
  assign acc.unit    = unit_sel;
  assign acc.enables = s_q.en;

  access_fault_check u_check (
    .clk     (clk),
    .sys_rst (sys_rst),
    .acc     (acc)
  );

  assign unit_fault = acc.fault;
  assign unit_ok    = acc.ok;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // enables are registered; a clock-gate cell downstream uses them
  assign watchdog_unit_clk     = s_q.en[unit_watchdog];
  assign adc_zero_clk          = s_q.en[unit_adc];
  assign pwm_unit_clk          = s_q.en[unit_pwm];
  assign gp_timer_zero_clk     = s_q.en[unit_timer];
  assign sync_serial_zero_clk  = s_q.en[unit_sync_serial];
  assign async_serial_zero_clk = s_q.en[unit_async_serial];
  assign adc_sample_rate_sel   = s_q.rate;
  assign irq                   = |(s_q.status & s_q.mask);

endmodule

/* tb/clock_gating_asserts.sv */
// port assertions for the peripheral clock gating block
// assumes a bind into peripheral_clock_gating, one clock domain
module clock_gating_asserts
  import clock_gating_pkg::*;
(
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        sleeping,
  input wire logic        deep_sleep,
  input wire logic        unit_req,
  input wire logic [2:0]  unit_sel,
  input wire logic        unit_fault,
  input wire logic        unit_ok,
  input wire logic        watchdog_unit_clk,
  input wire logic        gp_timer_zero_clk,
  input wire logic [3:0]  adc_sample_rate_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // run-set write while awake; the bench keeps power steady meanwhile
  wire logic wr_run0 = psel && penable && pwrite && paddr == run_gating_set0_off && !sleeping && !deep_sleep;
  // ----------------------------------------------------------------
  // unit access answers
  // ----------------------------------------------------------------
  answer_once_a: assert property (unit_req |=> unit_fault != unit_ok)
    else $error("unit access not answered once");
  no_answer_a: assert property (!unit_req |=> !unit_fault && !unit_ok)
    else $error("unit answer without request");
  gated_fault_a: assert property (unit_req && unit_sel == 3'h0 && !watchdog_unit_clk |=> unit_fault)
    else $error("unclocked watchdog access not faulted");
  bad_unit_a: assert property (unit_req && unit_sel > 3'h5 |=> unit_fault)
    else $error("missing unit access not faulted");
  clocked_ok_a: assert property (unit_req && unit_sel == 3'h3 && gp_timer_zero_clk |=> unit_ok)
    else $error("clocked timer access faulted");
  // ----------------------------------------------------------------
  // registers to outputs
  // ----------------------------------------------------------------
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  watchdog_on_a: assert property (wr_run0 && pwdata[watchdog_bit] |-> ##[1:3] watchdog_unit_clk)
    else $error("watchdog clock not enabled");
  watchdog_off_a: assert property (wr_run0 && !pwdata[watchdog_bit] |-> ##[1:3] !watchdog_unit_clk)
    else $error("watchdog clock not stopped");
  rate_set_a: assert property (wr_run0 && pwdata[adc_rate_msb:adc_rate_lsb] == adc_rate_250k
      |-> ##[1:3] adc_sample_rate_sel == adc_rate_250k)
    else $error("adc rate not applied");
  reset_off_a: assert property (disable iff (1'b0) sys_rst
      |-> !watchdog_unit_clk && !gp_timer_zero_clk && !unit_ok)
    else $error("outputs active in reset");
endmodule

/* tb/peripheral_clock_gating_tb.sv */
// self-checking bench: apb register accesses, power states, unit access
// assumes the package offsets and masks, zero-wait apb slave
module peripheral_clock_gating_tb
  import clock_gating_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
  logic sleeping, deep_sleep, unit_req, unit_fault, unit_ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0]  unit_sel;
  logic [3:0]  rate;
  wire logic [5:0] outs; // one output port drives each bit
  logic [1:0]  ans;
  int fail_count = 0;
  int n_compared = 0;
  localparam logic [11:0] offs [0:8] = '{run_gating_set0_off, run_gating_set1_off, sleep_gating_set0_off,
    sleep_gating_set1_off, deep_sleep_gating_set0_off, deep_sleep_gating_set1_off, run_clock_config_off,
    int_status_off, int_mask_off};
  localparam logic [31:0] msk [0:6] = '{set0_mask, set1_mask, set0_mask, set1_mask, set0_mask, set1_mask, config_mask};
  localparam logic [31:0] wval = 32'hffff_f1ff; // rate code kept at 250k, the device maximum
  peripheral_clock_gating dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sleeping(sleeping),
    .deep_sleep(deep_sleep), .unit_req(unit_req), .unit_sel(unit_sel), .unit_fault(unit_fault), .unit_ok(unit_ok),
    .watchdog_unit_clk(outs[0]), .adc_zero_clk(outs[1]), .pwm_unit_clk(outs[2]), .gp_timer_zero_clk(outs[3]),
    .sync_serial_zero_clk(outs[4]), .async_serial_zero_clk(outs[5]), .adc_sample_rate_sel(rate), .irq(irq));
  unit_side_model cpu (.clk(clk), .unit_fault(unit_fault), .unit_ok(unit_ok), .sleeping(sleeping),
    .deep_sleep(deep_sleep), .unit_req(unit_req), .unit_sel(unit_sel));
  // ----------------------------------------------------------------
  // clock, compare and bus tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run();
    if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; read data compared only on reads
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      complete_run();
    end
    if (!w) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, err});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // gating settles two edges after a change, three give margin
  task automatic outs_are(input logic [5:0] e, input logic [3:0] r);
    repeat (3) @(posedge clk);
    chk({26'h0, outs}, {26'h0, e});
    chk({28'h0, rate}, {28'h0, r});
  endtask
  task automatic units(input logic [6:0] en);
    for (int k = 0; k < 7; k++) begin
      cpu.access(k[2:0], ans);
      chk({30'h0, ans}, en[k] ? 32'h1 : 32'h2);
    end
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 9; i++) acc(1'b0, offs[i], 32'h0, 32'h0, 1'b0);
    outs_are(6'h00, adc_rate_125k);
    units(7'h00);
    for (int i = 0; i < 7; i++) begin
      acc(1'b1, offs[i], wval, 32'h0, 1'b0);
      acc(1'b0, offs[i], 32'h0, msk[i] & wval, 1'b0);
      acc(1'b1, offs[i], 32'h0, 32'h0, 1'b0);
    end
    acc(1'b1, 12'h0f0, 32'hffff_ffff, 32'h0, 1'b1);
    acc(1'b0, 12'h0f0, 32'h0, 32'h0, 1'b1);
    // interrupt: earlier faults are pending, masking and clearing
    acc(1'b1, int_mask_off, 32'h1, 32'h0, 1'b0);
    outs_are(6'h00, adc_rate_125k);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, int_status_off, irq_mask, 32'h0, 1'b0);
    outs_are(6'h00, adc_rate_125k);
    chk({31'h0, irq}, 32'h0);
    acc(1'b0, int_status_off, 32'h0, 32'h0, 1'b0);
    units(7'h00);
    chk({31'h0, irq}, 32'h1);
    acc(1'b1, int_mask_off, 32'h0, 32'h0, 1'b0);
    outs_are(6'h00, adc_rate_125k);
    chk({31'h0, irq}, 32'h0);
    acc(1'b0, int_status_off, 32'h0, 32'h1, 1'b0);
    acc(1'b1, int_status_off, irq_mask, 32'h0, 1'b0);
    // run set: all units enabled before use, rate 250k
    acc(1'b1, run_gating_set0_off, set0_mask & wval, 32'h0, 1'b0);
    acc(1'b1, run_gating_set1_off, set1_mask, 32'h0, 1'b0);
    outs_are(6'h3f, adc_rate_250k);
    units(7'h3f);
    acc(1'b1, run_gating_set0_off, 32'h0011_0000, 32'h0, 1'b0);
    outs_are(6'h3e, adc_rate_125k);
    units(7'h3e);
    acc(1'b1, sleep_gating_set0_off, 32'h0000_0008, 32'h0, 1'b0);
    acc(1'b1, sleep_gating_set1_off, 32'h0000_0001, 32'h0, 1'b0);
    acc(1'b1, deep_sleep_gating_set0_off, 32'h0010_0000, 32'h0, 1'b0);
    cpu.power(1'b1, 1'b0);
    outs_are(6'h3e, adc_rate_125k);
    cpu.power(1'b0, 1'b0);
    acc(1'b1, run_clock_config_off, 32'h1 << auto_gating_bit, 32'h0, 1'b0);
    cpu.power(1'b1, 1'b0);
    outs_are(6'h21, adc_rate_125k);
    units(7'h21);
    cpu.power(1'b1, 1'b1);
    outs_are(6'h04, adc_rate_125k);
    cpu.power(1'b0, 1'b0);
    outs_are(6'h3e, adc_rate_125k);
    // pending: faults of the unit accesses and every change of power state
    acc(1'b0, int_status_off, 32'h0, 32'h3, 1'b0);
    // second reset in mid-run clears every set
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    outs_are(6'h00, adc_rate_125k);
    acc(1'b0, run_gating_set0_off, 32'h0, 32'h0, 1'b0);
    complete_run();
  end
endmodule
bind peripheral_clock_gating clock_gating_asserts chk_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .sleeping(sleeping),
  .deep_sleep(deep_sleep), .unit_req(unit_req), .unit_sel(unit_sel), .unit_fault(unit_fault), .unit_ok(unit_ok),
  .watchdog_unit_clk(watchdog_unit_clk), .gp_timer_zero_clk(gp_timer_zero_clk),
  .adc_sample_rate_sel(adc_sample_rate_sel));

/* tb/unit_side_model.sv */
// processor and unit side: power state and unit access requests
// assumes the gating block answers one edge after the request edge
module unit_side_model
  import clock_gating_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       unit_fault,
  input  wire logic       unit_ok,
  output logic            sleeping,
  output logic            deep_sleep,
  output logic            unit_req,
  output logic [2:0]      unit_sel
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle and awake from time zero
  initial begin
    sleeping = 1'b0;
    deep_sleep = 1'b0;
    unit_req = 1'b0;
    unit_sel = 3'h0;
  end
  // power state moves only just after an edge
  task automatic power(input logic s, input logic d);
    @(posedge clk);
    sleeping <= s;
    deep_sleep <= d;
  endtask
  // one-cycle request; select is scrambled after, so stale values never help
  task automatic access(input logic [2:0] k, output logic [1:0] ans);
    @(posedge clk);
    unit_req <= 1'b1;
    unit_sel <= k;
    @(posedge clk);
    unit_req <= 1'b0;
    unit_sel <= ~k;
    // answer stands from the second edge to the next one; mid-cycle it is settled
    @(negedge clk);
    ans = {unit_fault, unit_ok};
  endtask
endmodule
